// ### rtl/dpios_top.sv
// Functional notes
// (RL1) single-shot plays memory once from first trigger, later triggers ignored
// (RL2) repeated replay loops pattern until repeat count or stop command
// (RL3) single restart plays pattern once per accepted trigger
// (RL4) multiple replay plays next equal segment on each trigger, no restart
// (RL5) gated replay outputs data only while gate at programmed level
// (RL6) gated sampling records pre area and post area per gate segment
// (RL7) sequence mode plays segments in stored order with loops and triggers
// (RL8) software switches sequence step; idle segments writable during play
// (RL9) each trigger time stored as a 128-bit timestamp entry
// (RL10) standard timestamp counter counts samples, cleared manually or at start
// (RL11) reference mode: upper counts reference edges, 40-bit lower counts samples
// (RL12) optional extra data: aux line states and or-trigger source
// (RL13) all channels share one direction, never mixed
// (RL14) either 16 or 32 active channels for record and replay
// (RL15) sampling and output update on programmable sample clock edge
// (RL16) stopped outputs show tristate, low, high, last or custom level
// (RL17) first and last replayed samples land 78 samples late
// (RL18) external, software, or/and and delayed triggers on chosen edges
// (RL19) pulse width, delay and holdoff programmable 0 to 4G-1 samples
// (RL20) re-arm quickly: only holdoff added after a trigger
// (RL21) pre and post trigger lengths in steps of 8 within limits
// (RL22) memory depth from 16, segment size from 8, steps of 8
// (RL23) after natural end outputs hold stop level until next start
`timescale 1ns/1ps
`default_nettype none
`include "dpios_defs.svh"
module dpios_top
  import dpios_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // register port
  input  wire dpios_breq_s  bus_req,
  output var  logic [31:0]  reg_rdata,
  // sample clock
  input  wire logic         sample_clk,
  // pattern channels
  input  wire logic [31:0]  data_in,
  output var  dpios_pout_s  data_pins,
  // auxiliary lines
  input  wire logic         aux_line_zero,
  input  wire logic         aux_line_one,
  input  wire logic         aux_line_two,
  input  wire logic         aux_line_three,
  // status
  output var  logic         run_active
);

  // ****************************
  // helper functions
  // ****************************
  function automatic logic [31:0] rsamp(
    input logic [`DPIOS_MEM_W-1:0][31:0] m,
    input logic                          w32,
    input logic [6:0]                    p);
    if (w32) begin
      rsamp = m[p[5:0]];
    end else if (p[0]) begin
      rsamp = {16'h0000, m[p[6:1]][31:16]};
    end else begin
      rsamp = {16'h0000, m[p[6:1]][15:0]};
    end
  endfunction : rsamp

  function automatic logic [7:0] clamp8(
    input logic [31:0] v,
    input logic [7:0]  lo,
    input logic [7:0]  hi);
    if (v >= {24'h00_0000, hi}) begin
      clamp8 = hi;
    end else begin
      clamp8 = {v[7:3], 3'b000};
    end
    if (clamp8 < lo) begin
      clamp8 = lo;
    end
  endfunction : clamp8

  function automatic logic [31:0] seqlen(input dpios_seq_s e);
    seqlen = {25'h000_0000, e.len_m1} + 32'h0000_0001;
  endfunction : seqlen

  function automatic logic [31:0] seqlp(input dpios_seq_s e);
    seqlp = (e.loops == 8'h00) ? 32'h0000_0001 : {24'h00_0000, e.loops};
  endfunction : seqlp

  // ****************************
  // state and decoded controls
  // ****************************
  dpios_st_s    r;
  dpios_st_s    n;
  dpios_mode_e  mode;
  logic         w32;
  logic         samp;
  logic [3:0]   aux;
  logic [3:0]   rise;
  logic [3:0]   fall;
  logic [3:0]   ev;
  logic [3:0]   lvl;
  logic [3:0]   tm;
  logic         lv;
  logic         cev;
  logic         hit;
  logic         acc;
  logic         trg;
  logic [3:0]   tsrc;
  logic         gate;
  logic [7:0]   maxs;
  logic [7:0]   depth_e;
  logic [7:0]   seg_e;
  logic [7:0]   pre_e;
  logic [31:0]  post_e;
  logic [31:0]  cmask;
  logic         cmd_wr;
  logic [31:0]  cmd;

  assign mode    = dpios_mode_e'(r.ctrl[`DPIOS_F_MODE]);
  // (RL14) channel count
  assign w32     = r.ctrl[`DPIOS_F_W32];
  assign cmask   = w32 ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  // (RL15) active edge select
  assign samp    = r.ctrl[`DPIOS_F_FALL] ? (r.sclk_q & ~sample_clk)
                                         : (~r.sclk_q & sample_clk);
  assign aux     = {aux_line_three, aux_line_two, aux_line_one,
                    aux_line_zero};
  assign rise    = aux & ~r.aux_q;
  assign fall    = ~aux & r.aux_q;
  assign tm      = r.ctrl[`DPIOS_F_TSRC];
  // (RL18) edge and combine logic
  assign ev      = ((r.ctrl[14]) ? rise : 4'h0) |
                   ((r.ctrl[15]) ? fall : 4'h0);
  assign lvl     = (r.ctrl[`DPIOS_F_TEDGE] == 2'b10) ? ~aux : aux;
  assign lv      = r.ctrl[`DPIOS_F_AND]
                   ? ((tm != 4'h0) && ((lvl | ~tm) == 4'hF))
                   : |(lvl & tm);
  assign cev     = r.ctrl[`DPIOS_F_AND]
                   ? (|(ev & tm) && ((lvl | ~tm) == 4'hF))
                   : |(ev & tm);
  // (RL19) pulse width qualifier
  assign hit     = (r.twid == 32'h0000_0000) ? cev
                   : (lv && (r.lcnt == r.twid - 32'h0000_0001));
  // (RL20) holdoff gates re-arm
  assign acc     = samp && (hit || r.sw_pend) && (r.hcnt == 32'h0000_0000)
                   && !r.dact;
  // (RL19) trigger delay
  assign trg     = samp && ((acc && (r.tdly == 32'h0000_0000)) ||
                            (r.dact && (r.dcnt == 32'h0000_0001)));
  assign tsrc    = r.dact ? r.src : (ev & tm);
  assign gate    = (aux_line_zero == r.ctrl[`DPIOS_F_GPOL]);
  assign maxs    = w32 ? `DPIOS_MAX32 : `DPIOS_MAX16;
  // (RL22) depth and segment limits
  assign depth_e = clamp8(r.depth, `DPIOS_MIN_DEP, maxs);
  assign seg_e   = clamp8(r.segsz, `DPIOS_MIN_SEG, maxs);
  // (RL21) pre and post limits
  assign pre_e   = clamp8(r.pre, `DPIOS_MIN_PRE, maxs);
  assign post_e  = ({r.post[31:3], 3'b000} < `DPIOS_MIN_PST)
                   ? `DPIOS_MIN_PST : {r.post[31:3], 3'b000};
  assign cmd_wr  = bus_req.wr && (bus_req.addr == `DPIOS_A_CMD);
  assign cmd     = cmd_wr ? bus_req.wdata : 32'h0000_0000;

  // ****************************
  // next state
  // ****************************
  always_comb begin
    logic [31:0] pd;
    logic        pv;
    logic [6:0]  wa;
    logic        we;
    logic [7:0]  nb;
    logic [2:0]  ni;
    logic [32:0] po;
    logic [31:0] dsamp;
    pd    = 32'h0000_0000;
    pv    = 1'b0;
    wa    = 7'h00;
    we    = 1'b0;
    nb    = 8'h00;
    ni    = 3'h0;
    po    = r.pipe[`DPIOS_OUT_LAT-1];
    dsamp = data_in & cmask;
    n     = r;
    n.rdata  = 32'h0000_0000;
    n.sclk_q = sample_clk;

    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        `DPIOS_A_CTRL:  n.ctrl  = bus_req.wdata;
        `DPIOS_A_REP:   n.rep   = bus_req.wdata;
        `DPIOS_A_DEPTH: n.depth = bus_req.wdata;
        `DPIOS_A_SEGSZ: n.segsz = bus_req.wdata;
        `DPIOS_A_PRE:   n.pre   = bus_req.wdata;
        `DPIOS_A_POST:  n.post  = bus_req.wdata;
        `DPIOS_A_TWID:  n.twid  = bus_req.wdata;
        `DPIOS_A_TDLY:  n.tdly  = bus_req.wdata;
        `DPIOS_A_HOLD:  n.hold  = bus_req.wdata;
        `DPIOS_A_STOPV: n.stopv = bus_req.wdata;
        `DPIOS_A_MADR:  n.madr  = bus_req.wdata[5:0];
        `DPIOS_A_TSIDX: n.tsidx = bus_req.wdata[1:0];
        `DPIOS_A_MDAT: begin
          // (RL8) memory open during play
          n.mem[r.madr] = bus_req.wdata;
          n.madr        = r.madr + 6'h01;
        end
        `DPIOS_A_SEQWR: begin
          n.seq[bus_req.wdata[`DPIOS_SQ_IDX]] = bus_req.wdata[25:0];
        end
        default: ;
      endcase
    end

    // register reads
    if (bus_req.rd) begin
      case (bus_req.addr)
        `DPIOS_A_CTRL:  n.rdata = r.ctrl;
        `DPIOS_A_STAT:  n.rdata = {17'h0_0000, r.ts_cnt, r.seg, r.ptr, r.st};
        `DPIOS_A_REP:   n.rdata = r.rep;
        `DPIOS_A_DEPTH: n.rdata = r.depth;
        `DPIOS_A_SEGSZ: n.rdata = r.segsz;
        `DPIOS_A_PRE:   n.rdata = r.pre;
        `DPIOS_A_POST:  n.rdata = r.post;
        `DPIOS_A_TWID:  n.rdata = r.twid;
        `DPIOS_A_TDLY:  n.rdata = r.tdly;
        `DPIOS_A_HOLD:  n.rdata = r.hold;
        `DPIOS_A_STOPV: n.rdata = r.stopv;
        `DPIOS_A_MADR:  n.rdata = {26'h000_0000, r.madr};
        `DPIOS_A_MDAT:  n.rdata = r.mem[r.madr];
        `DPIOS_A_TSIDX: n.rdata = {30'h0000_0000, r.tsidx};
        `DPIOS_A_TSW0:  n.rdata = r.ts[r.tsidx][31:0];
        `DPIOS_A_TSW1:  n.rdata = r.ts[r.tsidx][63:32];
        `DPIOS_A_TSW2:  n.rdata = r.ts[r.tsidx][95:64];
        `DPIOS_A_TSW3:  n.rdata = r.ts[r.tsidx][127:96];
        default:        n.rdata = 32'h0000_0000;
      endcase
    end

    // trigger engine
    if (samp) begin
      n.aux_q = aux;
      n.lcnt  = !lv ? 32'h0000_0000
              : (r.lcnt == 32'hFFFF_FFFF) ? r.lcnt
              : r.lcnt + 32'h0000_0001;
      if (r.dact) begin
        n.dcnt = r.dcnt - 32'h0000_0001;
        n.dact = (r.dcnt != 32'h0000_0001);
      end
      if (acc && (r.tdly != 32'h0000_0000)) begin
        n.dact = 1'b1;
        n.dcnt = r.tdly;
        n.src  = ev & tm;
      end
      if (r.hcnt != 32'h0000_0000) begin
        n.hcnt = r.hcnt - 32'h0000_0001;
      end
      // (RL20) holdoff after trigger
      if (trg) begin
        n.hcnt = r.hold;
      end
      // (RL11) reference timestamp mode
      if (r.ctrl[`DPIOS_F_TSREF]) begin
        n.tsc = rise[1] ? {r.tsc[63:40] + 24'h00_0001, 40'h00_0000_0000}
                        : {r.tsc[63:40], r.tsc[39:0] + 40'h00_0000_0001};
      end else begin
        // (RL10) sample counting timestamp
        n.tsc = r.tsc + 64'h0000_0000_0000_0001;
      end
      // (RL9) timestamp entry store
      if (trg) begin
        // (RL12) optional extra data
        n.ts[r.ts_wp] = {56'h00_0000_0000_0000,
                         r.ctrl[`DPIOS_F_TSEXT] ? aux : 4'h0,
                         (r.ctrl[`DPIOS_F_TSEXT] && !r.ctrl[`DPIOS_F_AND])
                           ? tsrc : 4'h0,
                         r.tsc};
        n.ts_wp  = r.ts_wp + 2'h1;
        n.ts_cnt = (r.ts_cnt == 3'h4) ? r.ts_cnt : r.ts_cnt + 3'h1;
      end
    end
    n.sw_pend = cmd[`DPIOS_C_SWT] ? 1'b1 : (samp ? 1'b0 : r.sw_pend);

    // replay and record sequencer
    unique case (r.st)
      ST_IDLE: ;
      ST_ARM: begin
        // (RL5) gate opens replay
        if (samp && (mode == M_GATED) && gate) begin
          n.st = ST_PLAY;
        // (RL3) each trigger starts a pass
        end else if (trg && (mode != M_GATED)) begin
          n.st = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (samp && (mode == M_GATED) && !gate) begin
          n.st = ST_ARM;
        end else if (samp) begin
          pv      = 1'b1;
          pd      = rsamp(r.mem, w32, r.ptr);
          n.ptr   = r.ptr + 7'h01;
          n.cnt   = r.cnt - 32'h0000_0001;
          if (r.cnt == 32'h0000_0001) begin
            unique case (mode)
              // (RL1) single pass then idle
              M_SINGLE: n.st = ST_IDLE;
              M_REPEAT: begin
                // (RL2) repeat count
                if ((r.rep != 32'h0000_0000) &&
                    (r.loops <= 32'h0000_0001)) begin
                  n.st = ST_IDLE;
                end else begin
                  n.loops = r.loops - 32'h0000_0001;
                  n.ptr   = 7'h00;
                  n.cnt   = {24'h00_0000, depth_e};
                end
              end
              M_RESTART: begin
                n.st  = ST_ARM;
                n.ptr = 7'h00;
                n.cnt = {24'h00_0000, depth_e};
              end
              M_MULTI: begin
                // (RL4) advance to next segment
                nb = {1'b0, r.base} + seg_e;
                if (nb >= depth_e) begin
                  nb = 8'h00;
                end
                n.base = nb[6:0];
                n.ptr  = nb[6:0];
                n.cnt  = {24'h00_0000, seg_e};
                n.st   = ST_ARM;
              end
              M_GATED: begin
                n.ptr = 7'h00;
                n.cnt = {24'h00_0000, depth_e};
              end
              M_SEQ: begin
                // (RL7) loops then next step
                if (r.loops > 32'h0000_0001) begin
                  n.loops = r.loops - 32'h0000_0001;
                  n.ptr   = r.seq[r.seg].start;
                  n.cnt   = seqlen(r.seq[r.seg]);
                end else begin
                  // (RL8) software step switch
                  ni      = r.swq ? r.swi : r.seq[r.seg].nxt;
                  n.swq   = 1'b0;
                  n.seg   = ni;
                  n.ptr   = r.seq[ni].start;
                  n.cnt   = seqlen(r.seq[ni]);
                  n.loops = seqlp(r.seq[ni]);
                  n.st    = r.seq[ni].trig ? ST_ARM : ST_PLAY;
                end
              end
              M_REC:  n.st = ST_IDLE;
              M_RECG: n.st = ST_IDLE;
            endcase
          end
        end
      end
      ST_REC: begin
        if (samp) begin
          we = 1'b1;
          // (RL6) pre area ring then linear
          if (!r.open && (r.pcnt == 32'h0000_0000)) begin
            wa     = r.rbase + r.pofs;
            n.pofs = ({1'b0, r.pofs} + 8'h01 >= pre_e) ? 7'h00
                                                      : r.pofs + 7'h01;
            if ((mode == M_RECG) ? gate : trg) begin
              nb     = {1'b0, r.rbase} + pre_e;
              n.lp   = nb[6:0];
              n.open = (mode == M_RECG);
              n.pcnt = (mode == M_RECG) ? 32'h0000_0000 : post_e;
              if (nb >= depth_e) begin
                n.st = ST_IDLE;
              end
            end
          end else begin
            wa   = r.lp;
            n.lp = r.lp + 7'h01;
            if (r.open && !gate) begin
              n.open = 1'b0;
              n.pcnt = post_e;
            end else if (!r.open) begin
              n.pcnt = r.pcnt - 32'h0000_0001;
              if (r.pcnt == 32'h0000_0001) begin
                n.rbase = r.lp + 7'h01;
                n.pofs  = 7'h00;
                if (mode == M_REC) begin
                  n.st = ST_IDLE;
                end
              end
            end
            if ({1'b0, r.lp} + 8'h01 >= depth_e) begin
              n.st = ST_IDLE;
            end
          end
        end
      end
    endcase
    if (we) begin
      if (w32) begin
        n.mem[wa[5:0]] = dsamp;
      end else if (wa[0]) begin
        n.mem[wa[6:1]][31:16] = dsamp[15:0];
      end else begin
        n.mem[wa[6:1]][15:0] = dsamp[15:0];
      end
    end

    // output latency line and stop level
    if (samp) begin
      // (RL17) fixed output latency
      n.pipe = {r.pipe[`DPIOS_OUT_LAT-2:0], {pv, pd}};
      if (po[32]) begin
        n.dout = po[31:0];
        n.last = po[31:0];
        n.oe   = 32'hFFFF_FFFF;
      end else begin
        // (RL16) stop level select
        // (RL23) hold stop level after end
        case (dpios_stop_e'(r.ctrl[`DPIOS_F_STOP]))
          SL_LOW:  begin n.dout = 32'h0000_0000; n.oe = 32'hFFFF_FFFF; end
          SL_HIGH: begin n.dout = 32'hFFFF_FFFF; n.oe = 32'hFFFF_FFFF; end
          SL_HOLD: begin n.dout = r.last;        n.oe = 32'hFFFF_FFFF; end
          SL_CUST: begin n.dout = r.stopv;       n.oe = 32'hFFFF_FFFF; end
          default: begin n.dout = 32'h0000_0000; n.oe = 32'h0000_0000; end
        endcase
      end
      n.dout = n.dout & cmask;
      // (RL13) one direction for all
      n.oe   = r.ctrl[`DPIOS_F_DIR] ? (n.oe & cmask) : 32'h0000_0000;
    end

    // commands
    if (cmd[`DPIOS_C_SWSEL]) begin
      n.swq = 1'b1;
      n.swi = cmd[`DPIOS_C_SWIDX];
    end
    if (cmd[`DPIOS_C_START]) begin
      n.ptr   = 7'h00;
      n.base  = 7'h00;
      n.seg   = 3'h0;
      n.cnt   = (mode == M_MULTI) ? {24'h00_0000, seg_e}
                                  : {24'h00_0000, depth_e};
      n.loops = r.rep;
      n.lp    = 7'h00;
      n.rbase = 7'h00;
      n.pofs  = 7'h00;
      n.pcnt  = 32'h0000_0000;
      n.open  = 1'b0;
      if (mode == M_SEQ) begin
        n.ptr   = r.seq[0].start;
        n.cnt   = seqlen(r.seq[0]);
        n.loops = seqlp(r.seq[0]);
      end
      n.st = ((mode == M_REC) || (mode == M_RECG)) ? ST_REC : ST_ARM;
      // (RL10) clear on start option
      if (r.ctrl[`DPIOS_F_TSCLR]) begin
        n.tsc = 64'h0000_0000_0000_0000;
      end
    end
    if (cmd[`DPIOS_C_TSCLR]) begin
      n.tsc    = 64'h0000_0000_0000_0000;
      n.ts_wp  = 2'h0;
      n.ts_cnt = 3'h0;
    end
    if (cmd[`DPIOS_C_STOP]) begin
      n.st   = ST_IDLE;
      n.pipe = '0;
    end
  end

  // ****************************
  // state register
  // ****************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata  = r.rdata;
  assign data_pins  = '{dat: r.dout, oe: r.oe};
  assign run_active = (r.st != ST_IDLE);

endmodule : dpios_top
`default_nettype wire

// ### rtl/dpios_defs.svh
`ifndef DPIOS_DEFS_SVH
`define DPIOS_DEFS_SVH
// ****************************
// register offsets
// ****************************
`define DPIOS_A_CTRL   8'h00
`define DPIOS_A_CMD    8'h04
`define DPIOS_A_STAT   8'h08
`define DPIOS_A_REP    8'h0C
`define DPIOS_A_DEPTH  8'h10
`define DPIOS_A_SEGSZ  8'h14
`define DPIOS_A_PRE    8'h18
`define DPIOS_A_POST   8'h1C
`define DPIOS_A_TWID   8'h20
`define DPIOS_A_TDLY   8'h24
`define DPIOS_A_HOLD   8'h28
`define DPIOS_A_STOPV  8'h2C
`define DPIOS_A_MADR   8'h30
`define DPIOS_A_MDAT   8'h34
`define DPIOS_A_SEQWR  8'h38
`define DPIOS_A_TSIDX  8'h3C
`define DPIOS_A_TSW0   8'h40
`define DPIOS_A_TSW1   8'h44
`define DPIOS_A_TSW2   8'h48
`define DPIOS_A_TSW3   8'h4C
// ****************************
// control and command fields
// ****************************
`define DPIOS_F_MODE   2:0
`define DPIOS_F_DIR    3
`define DPIOS_F_W32    4
`define DPIOS_F_FALL   5
`define DPIOS_F_STOP   8:6
`define DPIOS_F_TSRC   12:9
`define DPIOS_F_AND    13
`define DPIOS_F_TEDGE  15:14
`define DPIOS_F_GPOL   16
`define DPIOS_F_TSREF  17
`define DPIOS_F_TSEXT  18
`define DPIOS_F_TSCLR  19
`define DPIOS_C_START  0
`define DPIOS_C_STOP   1
`define DPIOS_C_SWT    2
`define DPIOS_C_TSCLR  3
`define DPIOS_C_SWSEL  4
`define DPIOS_C_SWIDX  10:8
`define DPIOS_SQ_IDX   28:26
// ****************************
// sizes and limits
// ****************************
`define DPIOS_OUT_LAT  78
`define DPIOS_MEM_W    64
`define DPIOS_SEQ_N    8
`define DPIOS_TS_N     4
`define DPIOS_MIN_DEP  8'h10
`define DPIOS_MIN_SEG  8'h08
`define DPIOS_MIN_PRE  8'h08
`define DPIOS_MIN_PST  32'h0000_0008
`define DPIOS_MAX32    8'h40
`define DPIOS_MAX16    8'h80
`endif

// ### rtl/dpios_pkg.sv
package dpios_pkg;
`include "dpios_defs.svh"
  typedef enum logic [2:0] {
    M_SINGLE = 3'b000, M_REPEAT = 3'b001, M_RESTART = 3'b010,
    M_MULTI  = 3'b011, M_GATED  = 3'b100, M_SEQ     = 3'b101,
    M_REC    = 3'b110, M_RECG   = 3'b111
  } dpios_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ARM = 2'b01, ST_PLAY = 2'b10, ST_REC = 2'b11
  } dpios_state_e;
  typedef enum logic [2:0] {
    SL_TRI = 3'b000, SL_LOW = 3'b001, SL_HIGH = 3'b010,
    SL_HOLD = 3'b011, SL_CUST = 3'b100
  } dpios_stop_e;
  typedef struct packed {
    logic [6:0] start;
    logic [6:0] len_m1;
    logic [7:0] loops;
    logic       trig;
    logic [2:0] nxt;
  } dpios_seq_s;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dpios_breq_s;
  typedef struct packed {
    logic [31:0] dat;
    logic [31:0] oe;
  } dpios_pout_s;
  typedef struct packed {
    dpios_state_e                      st;
    logic [31:0]                       ctrl, rep, depth, segsz, pre, post;
    logic [31:0]                       twid, tdly, hold, stopv;
    logic [5:0]                        madr;
    logic [1:0]                        tsidx;
    logic [`DPIOS_MEM_W-1:0][31:0]     mem;
    dpios_seq_s [`DPIOS_SEQ_N-1:0]     seq;
    logic [`DPIOS_TS_N-1:0][127:0]     ts;
    logic [1:0]                        ts_wp;
    logic [2:0]                        ts_cnt;
    logic [63:0]                       tsc;
    logic                              sclk_q;
    logic [3:0]                        aux_q;
    logic                              sw_pend;
    logic [31:0]                       lcnt, dcnt, hcnt;
    logic                              dact;
    logic [3:0]                        src;
    logic [`DPIOS_OUT_LAT-1:0][32:0]   pipe;
    logic [31:0]                       last, dout, oe, rdata;
    logic [6:0]                        ptr, base;
    logic [31:0]                       cnt, loops;
    logic [2:0]                        seg;
    logic                              swq;
    logic [2:0]                        swi;
    logic [6:0]                        lp, rbase, pofs;
    logic [31:0]                       pcnt;
    logic                              open;
  } dpios_st_s;
endpackage : dpios_pkg

// ### sim/dpios_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dpios_chk
  import dpios_pkg::*;
(
  // bus
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire dpios_breq_s bus_req,
  input wire logic [31:0] reg_rdata,
  // pins
  input wire dpios_pout_s data_pins,
  input wire logic        sample_clk,
  input wire logic        run_active
);
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_rd_slot: assert property (reg_rdata != 32'h0 |-> $past(bus_req.rd))
    else $error("stray read data");
  chk_cmd_zero: assert property ($past(bus_req.rd)
    && $past(bus_req.addr) == 8'h04 |-> reg_rdata == 32'h0)
    else $error("command read not zero");
  chk_hole_zero: assert property ($past(bus_req.rd)
    && $past(bus_req.addr) > 8'h4c |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_stat_run: assert property ($past(bus_req.rd)
    && $past(bus_req.addr) == 8'h08
    |-> (reg_rdata[1:0] != 2'h0) == $past(run_active))
    else $error("state field wrong");
  chk_start_run: assert property ($rose(run_active) |->
    $past(bus_req.wr) && $past(bus_req.wdata[0])
    && $past(bus_req.addr) == 8'h04)
    else $error("run without start");
  chk_stop_idle: assert property (bus_req.wr && bus_req.wdata[1]
    && !bus_req.wdata[0] && bus_req.addr == 8'h04 |-> ##[1:2] !run_active)
    else $error("stop not obeyed");
  chk_samp_only: assert property ($changed(data_pins) |->
    $past(sample_clk) != $past(sample_clk, 2))
    else $error("pins moved off sample");
  chk_oe_same: assert property (data_pins.oe[15:0] == 16'h0
    || data_pins.oe[15:0] == 16'hffff)
    else $error("mixed direction");
endmodule : dpios_chk
`default_nettype wire

// ### sim/dpios_ext.sv
`timescale 1ns/1ps
`default_nettype none
module dpios_ext (
  // control
  input  wire logic        mclk,
  input  wire logic        trg,
  // lines to card
  output var  logic        sample_clk,
  output var  logic [3:0]  aux,
  output var  logic [31:0] data_in
);
  logic [1:0]  div_r = 2'h0;
  logic [3:0]  hold_r = 4'h0;
  logic [31:0] pat_r = 32'h0000_0001;
  // sample clock at mclk/4, trigger held several samples
  always @(posedge mclk) begin
    div_r  <= div_r + 2'h1;
    pat_r  <= {pat_r[30:0], pat_r[31]};
    hold_r <= trg ? 4'hf : hold_r - {3'h0, hold_r != 4'h0};
  end
  assign sample_clk = div_r[1];
  assign aux        = {3'h0, hold_r != 4'h0};
  assign data_in    = pat_r;
endmodule : dpios_ext
`default_nettype wire

// ### sim/dpios_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dpios_top_test;
  import dpios_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        trg = 1'b0;
  dpios_breq_s bus_req = '0;
  logic [31:0] reg_rdata, data_in;
  logic [3:0]  aux;
  logic        sample_clk, run_active;
  dpios_pout_s data_pins;
  int          error_cnt = 0;
  int          n_checks = 0;
  dpios_top i_dut (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .sample_clk(sample_clk), .data_in(data_in),
    .data_pins(data_pins), .aux_line_zero(aux[0]), .aux_line_one(aux[1]),
    .aux_line_two(aux[2]), .aux_line_three(aux[3]),
    .run_active(run_active));
  dpios_ext i_ext (.mclk(mclk), .trg(trg), .sample_clk(sample_clk),
    .aux(aux), .data_in(data_in));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata & m, e);
  endtask : rd
  task automatic nxt();
    @(posedge sample_clk);
    @(posedge mclk);
    #1;
  endtask : nxt
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // ****************
  // scenarios
  // ****************
  task automatic t_single();
    wr(8'h0c, 32'h0000_0005);
    rd(8'h0c, 32'h0000_0005, 32'hffff_ffff);
    rd(8'h04, 32'h0, 32'hffff_ffff);
    rd(8'h7c, 32'h0, 32'hffff_ffff);
    wr(8'h30, 32'h0);
    for (int i = 0; i < 16; i++) wr(8'h34, 32'h1000_0000 + i);
    wr(8'h10, 32'h0000_0010);
    wr(8'h00, 32'h0008_0058);
    wr(8'h04, 32'h0000_0001);
    rd(8'h08, 32'h0000_0001, 32'h0000_0003);
    @(posedge sample_clk);
    @(posedge mclk);
    wr(8'h04, 32'h0000_0004);
    repeat (80) @(posedge sample_clk);
    chk(data_pins.dat, 32'h0);
    @(posedge mclk);
    #1;
    for (int i = 0; i < 16; i++) begin
      chk(data_pins.dat, 32'h1000_0000 + i);
      nxt();
    end
    chk(data_pins.dat, 32'h0);
    chk(data_pins.oe, 32'hffff_ffff);
    @(posedge mclk);
    rd(8'h08, 32'h0000_1000, 32'h0000_7003);
    wr(8'h04, 32'h0000_0004);
    repeat (90) nxt();
    chk(data_pins.dat, 32'h0);
    @(posedge mclk);
    $display("single shot done");
  endtask : t_single
  task automatic t_repeat();
    wr(8'h2c, 32'ha5a5_5a5a);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h0000_4319);
    wr(8'h04, 32'h0000_0001);
    trg <= 1'b1;
    @(posedge mclk);
    trg <= 1'b0;
    repeat (200) nxt();
    chk({data_pins.dat[31:4], 4'h0}, 32'h1000_0000);
    chk({31'h0, run_active}, 32'h1);
    @(posedge mclk);
    wr(8'h04, 32'h0000_0002);
    repeat (3) nxt();
    chk(data_pins.dat, 32'ha5a5_5a5a);
    chk({31'h0, run_active}, 32'h0);
    $display("repeat done");
  endtask : t_repeat
  task automatic t_restart();
    @(posedge mclk);
    wr(8'h00, 32'h0000_005a);
    wr(8'h04, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      @(posedge sample_clk);
      @(posedge mclk);
      wr(8'h04, 32'h0000_0004);
      repeat (80) @(posedge sample_clk);
      @(posedge mclk);
      #1;
      chk(data_pins.dat, 32'h1000_0000);
      repeat (20) nxt();
    end
    chk({31'h0, run_active}, 32'h1);
    @(posedge mclk);
    wr(8'h04, 32'h0000_0002);
    $display("restart done");
  endtask : t_restart
  initial begin
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_single();
    t_repeat();
    t_restart();
    results();
  end
endmodule : dpios_top_test
bind dpios_top dpios_chk i_chk (.mclk(mclk), .rst_b(rst_b),
  .bus_req(bus_req), .reg_rdata(reg_rdata), .data_pins(data_pins),
  .sample_clk(sample_clk), .run_active(run_active));
`default_nettype wire
